// ---- tmr3_control.sv ----
// timer three control: counter, flags, pin toggle, capture/compare and register port
`timescale 1ns/1ps
`default_nettype none
`include "tmr3_defines.svh"

module tmr3_control (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire tmr3_pkg::tmr3_req_t req,
  output logic [7:0]             rdata_q,
  input  wire logic              timer_ext_pin_in,
  output logic                   timer_ext_pin_out_q,
  output logic                   timer_ext_pin_oe_q,
  input  wire logic              capture_pin,
  output logic                   irq_q
);
  import tmr3_pkg::*;

  // ==========================================================
  // state
  tmr3_ctrl_t  ctrl_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] cap_q;
  logic [1:0]  sts_q;
  logic [1:0]  en_q;
  logic [2:0]  ext_sync_q;
  logic [2:0]  cap_sync_q;

  // ==========================================================
  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_q <= 3'h7;
      cap_sync_q <= 3'h7;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], timer_ext_pin_in};
      cap_sync_q <= {cap_sync_q[1:0], capture_pin};
    end
  end

  logic ext_fall;
  logic cap_fall;
  assign ext_fall = ext_sync_q[2] & ~ext_sync_q[1];
  assign cap_fall = cap_sync_q[2] & ~cap_sync_q[1];

  // ==========================================================
  // events
  logic        wr_ctrl;
  logic        wr_lo;
  logic        wr_hi;
  logic        cnt_wr;
  logic        inc;
  logic        ovf_ev;
  logic        cap_ev;
  logic        cmp_ev;
  logic        clr_ev;
  logic [15:0] cnt_inc;

  assign wr_ctrl = req.wr && (req.addr == `TMR3_OFF_CTRL);
  assign wr_lo   = req.wr && (req.addr == `TMR3_OFF_CNT_LO);
  assign wr_hi   = req.wr && (req.addr == `TMR3_OFF_CNT_HI);
  assign cnt_wr  = wr_lo | wr_hi;
  assign cnt_inc = count_q + 16'h0001;
  // halted counter sees no increment at all
  assign inc     = ctrl_q.run_control &
                   (ctrl_q.count_source_select ? ext_fall : 1'b1);
  assign ovf_ev  = inc && (count_q == `TMR3_CNT_MAX);
  assign cap_ev  = (ctrl_q.mode_select == TMR3_MODE_CAPTURE) && cap_fall;
  assign cmp_ev  = (ctrl_q.mode_select == TMR3_MODE_COMPARE) && inc &&
                   (cnt_inc == cap_q);
  assign clr_ev  = (cap_ev | cmp_ev) & ctrl_q.match_auto_clear_enable;

  // ==========================================================
  // counter; software write beats hardware
  always_comb begin
    count_d = count_q;
    if (cnt_wr) begin
      if (wr_lo) begin
        count_d[7:0] = req.wdata;
      end
      if (wr_hi) begin
        count_d[15:8] = req.wdata;
      end
    end else if (clr_ev) begin
      count_d = `TMR3_CNT_RST;
    end else if (ovf_ev && (ctrl_q.mode_select == TMR3_MODE_RELOAD)) begin
      count_d = cap_q;
    end else if (inc) begin
      count_d = cnt_inc;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `TMR3_CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  // ==========================================================
  // capture register, doubles as reload and compare value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_q <= `TMR3_CAP_RST;
    end else if (cap_ev) begin
      cap_q <= count_q;
    end else if (req.wr && (req.addr == `TMR3_OFF_CAP_LO)) begin
      cap_q[7:0] <= req.wdata;
    end else if (req.wr && (req.addr == `TMR3_OFF_CAP_HI)) begin
      cap_q[15:8] <= req.wdata;
    end
  end

  // ==========================================================
  // control register; a hardware set wins over a software clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= tmr3_ctrl_t'(`TMR3_CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= tmr3_ctrl_t'(req.wdata);
      end
      if (ovf_ev) begin
        ctrl_q.overflow_flag <= 1'b1;
      end
      if (cap_ev | cmp_ev) begin
        ctrl_q.capture_compare_event_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // pin toggle; pin is driven while the toggle enable is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_ext_pin_out_q <= 1'b0;
      timer_ext_pin_oe_q  <= 1'b0;
    end else begin
      timer_ext_pin_oe_q <= ctrl_q.toggle_output_enable;
      if (ovf_ev && ctrl_q.toggle_output_enable) begin
        timer_ext_pin_out_q <= ~timer_ext_pin_out_q;
      end
    end
  end

  // ==========================================================
  // interrupt status: bit 0 overflow, bit 1 capture/compare
  logic [1:0] sts_set;
  logic [1:0] sts_clr;
  assign sts_set = {cap_ev | cmp_ev, ovf_ev};
  assign sts_clr = (req.wr && (req.addr == `TMR3_OFF_IRQ_CLR)) ? req.wdata[1:0] : 2'h0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= `TMR3_IRQ_RST;
      en_q  <= `TMR3_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
      irq_q <= |(sts_q & en_q);
      if (req.wr && (req.addr == `TMR3_OFF_IRQ_EN)) begin
        en_q <= req.wdata[1:0];
      end
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `TMR3_OFF_CTRL:    rdata_q <= ctrl_q;
        `TMR3_OFF_CNT_LO:  rdata_q <= count_q[7:0];
        `TMR3_OFF_CNT_HI:  rdata_q <= count_q[15:8];
        `TMR3_OFF_CAP_LO:  rdata_q <= cap_q[7:0];
        `TMR3_OFF_CAP_HI:  rdata_q <= cap_q[15:8];
        `TMR3_OFF_IRQ_STS: rdata_q <= {6'h00, sts_q};
        `TMR3_OFF_IRQ_EN:  rdata_q <= {6'h00, en_q};
        default:           rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_hold_count;
    !inc && !cnt_wr && !clr_ev;
  endsequence

  a_ovf_sets_flag: assert property (ovf_ev |=> ctrl_q.overflow_flag)
    else $error("overflow did not set flag");
  a_ovf_flag_sticky: assert property (ctrl_q.overflow_flag && !wr_ctrl |=> ctrl_q.overflow_flag)
    else $error("overflow flag cleared by hardware");
  a_sw_flag_write: assert property (wr_ctrl && !ovf_ev |=>
      ctrl_q.overflow_flag == $past(req.wdata[`TMR3_BIT_OVF]))
    else $error("software write to overflow flag lost");
  a_evt_sets_flag: assert property (cap_ev || cmp_ev |=> ctrl_q.capture_compare_event_flag)
    else $error("event did not set flag");
  a_pin_toggles: assert property (ovf_ev && ctrl_q.toggle_output_enable |=>
      timer_ext_pin_out_q != $past(timer_ext_pin_out_q))
    else $error("pin did not toggle on overflow");
  a_pin_steady: assert property (!ovf_ev |=> $stable(timer_ext_pin_out_q))
    else $error("pin toggled without overflow");
  a_match_clear: assert property (clr_ev && !cnt_wr |=> count_q == 16'h0000)
    else $error("counter not cleared on match");
  a_internal_count: assert property (ctrl_q.run_control && !ctrl_q.count_source_select &&
      !cnt_wr && !clr_ev && !ovf_ev |=> count_q == $past(count_q) + 16'h0001)
    else $error("internal clock did not increment");
  a_reload_value: assert property (ovf_ev && ctrl_q.mode_select == TMR3_MODE_RELOAD &&
      !cnt_wr |=> count_q == $past(cap_q))
    else $error("auto reload value wrong");
  a_halt_holds: assert property (s_hold_count |=> $stable(count_q))
    else $error("count changed while halted");

endmodule : tmr3_control
`default_nettype wire

// ---- tmr3_defines.svh ----
// constants of the timer three control block: offsets, field positions, reset values
`ifndef TMR3_DEFINES_SVH
`define TMR3_DEFINES_SVH

// ==========================================================
// register offsets
`define TMR3_ADDR_W       4
`define TMR3_OFF_CTRL     4'h0
`define TMR3_OFF_CNT_LO   4'h1
`define TMR3_OFF_CNT_HI   4'h2
`define TMR3_OFF_CAP_LO   4'h3
`define TMR3_OFF_CAP_HI   4'h4
`define TMR3_OFF_IRQ_STS  4'h5
`define TMR3_OFF_IRQ_CLR  4'h6
`define TMR3_OFF_IRQ_EN   4'h7

// ==========================================================
// control field positions
`define TMR3_BIT_OVF      7
`define TMR3_BIT_EVT      6
`define TMR3_BIT_SRC      5
`define TMR3_BIT_TOE      4
`define TMR3_BIT_MCLR     3
`define TMR3_BIT_RUN      2

// ==========================================================
// reset values and counter top value
`define TMR3_CTRL_RST     8'h00
`define TMR3_CNT_RST      16'h0000
`define TMR3_CAP_RST      16'h0000
`define TMR3_IRQ_RST      2'h0
`define TMR3_CNT_MAX      16'hFFFF

`endif

// ---- tmr3_pkg.sv ----
// types of the timer three control block
package tmr3_pkg;

  typedef enum logic [1:0] {
    TMR3_MODE_TIMER   = 2'h0,
    TMR3_MODE_CAPTURE = 2'h1,
    TMR3_MODE_RELOAD  = 2'h2,
    TMR3_MODE_COMPARE = 2'h3
  } tmr3_mode_t;

  typedef struct packed {
    logic       overflow_flag;
    logic       capture_compare_event_flag;
    logic       count_source_select;
    logic       toggle_output_enable;
    logic       match_auto_clear_enable;
    logic       run_control;
    tmr3_mode_t mode_select;
  } tmr3_ctrl_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr3_req_t;

endpackage : tmr3_pkg

// ---- tmr3_pin_model.sv ----
// far-side model: drives the external count pin and the capture pin
`timescale 1ns/1ps
`default_nettype none
module tmr3_pin_model (
  input  wire logic clock,
  input  wire logic pin_drv,
  input  wire logic pin_oe,
  output logic      ext_lvl,
  output logic      cap_lvl
);
  logic src_q;
  // pulled up when idle; the device wins the wire while it drives
  assign ext_lvl = pin_oe ? pin_drv : src_q;
  initial begin
    src_q   = 1'b1;
    cap_lvl = 1'b1;
  end
  // each phase lasts at least 4 cycles so the 3-stage sync sees it
  task automatic fall(input bit cap, input int n);
    repeat (n) begin
      @(posedge clock);
      if (cap) cap_lvl <= 1'b0; else src_q <= 1'b0;
      repeat (4) @(posedge clock);
      if (cap) cap_lvl <= 1'b1; else src_q <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask : fall
endmodule : tmr3_pin_model
`default_nettype wire

// ---- tb.sv ----
// self-checking bench of the timer three control block
`timescale 1ns/1ps
`default_nettype none
`include "tmr3_defines.svh"
module tb;
  import tmr3_pkg::*;
  logic       clock, rst_n, pin_out, pin_oe, irq, ext, cap;
  logic [7:0] rdata, v;
  tmr3_req_t  req;
  int         errors, checks, seed, n;

  tmr3_control u_dut (.clock(clock), .rst_n(rst_n), .req(req), .rdata_q(rdata),
    .timer_ext_pin_in(ext), .timer_ext_pin_out_q(pin_out), .timer_ext_pin_oe_q(pin_oe),
    .capture_pin(cap), .irq_q(irq));
  tmr3_pin_model u_pin (.clock(clock), .pin_drv(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext), .cap_lvl(cap));

  // control byte: {src, toggle, match clear, run} and mode
  function automatic logic [7:0] ctl(input logic [3:0] b, input tmr3_mode_t m);
    return {2'h0, b, m};
  endfunction : ctl

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one strobe cycle, then one idle cycle so req is set once per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= {a, d, 1'b1, 1'b0};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    req <= '0;
    #1 cmp(rdata, exp);
    @(posedge clock);
  endtask : rdc

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end

  initial begin
    seed   = 51750;
    errors = 0;
    checks = 0;
    req    = '0;
    rst_n  = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(`TMR3_OFF_CTRL, `TMR3_CTRL_RST);
    rdc(4'h9, 8'h00);
    // halted counter keeps both bytes
    v = 8'($random(seed));
    wr(`TMR3_OFF_CNT_LO, v);
    wr(`TMR3_OFF_CNT_HI, ~v);
    repeat (20) @(posedge clock);
    rdc(`TMR3_OFF_CNT_LO, v);
    rdc(`TMR3_OFF_CNT_HI, ~v);
    // overflow from the top value: flag, pin toggle, interrupt
    wr(`TMR3_OFF_IRQ_EN, 8'h01);
    wr(`TMR3_OFF_CNT_LO, 8'hFF);
    wr(`TMR3_OFF_CNT_HI, 8'hFF);
    wr(`TMR3_OFF_CTRL, ctl(4'h5, TMR3_MODE_TIMER));
    repeat (4) @(posedge clock);
    cmp({7'h0, pin_out}, 8'h01);
    cmp({7'h0, pin_oe}, 8'h01);
    cmp({7'h0, irq}, 8'h01);
    rdc(`TMR3_OFF_CTRL, 8'h80 | ctl(4'h5, TMR3_MODE_TIMER));
    rdc(`TMR3_OFF_IRQ_STS, 8'h01);
    wr(`TMR3_OFF_CTRL, 8'h00);
    wr(`TMR3_OFF_IRQ_CLR, 8'h01);
    rdc(`TMR3_OFF_CTRL, 8'h00);
    cmp({7'h0, irq}, 8'h00);
    wr(`TMR3_OFF_CTRL, 8'hC0);
    rdc(`TMR3_OFF_CTRL, 8'hC0);
    // external falling edges only
    wr(`TMR3_OFF_CNT_LO, 8'h00);
    wr(`TMR3_OFF_CNT_HI, 8'h00);
    wr(`TMR3_OFF_CTRL, ctl(4'h9, TMR3_MODE_TIMER));
    n = 1 + ($random(seed) & 7);
    u_pin.fall(1'b0, n);
    rdc(`TMR3_OFF_CNT_LO, n[7:0]);
    // capture with automatic clear
    wr(`TMR3_OFF_CTRL, ctl(4'hB, TMR3_MODE_CAPTURE));
    u_pin.fall(1'b1, 1);
    rdc(`TMR3_OFF_CAP_LO, n[7:0]);
    rdc(`TMR3_OFF_CNT_LO, 8'h00);
    rdc(`TMR3_OFF_CTRL, 8'h40 | ctl(4'hB, TMR3_MODE_CAPTURE));
    // compare at 0x0100 with clear: high byte never reaches 1
    wr(`TMR3_OFF_CTRL, 8'h00);
    wr(`TMR3_OFF_CAP_LO, 8'h00);
    wr(`TMR3_OFF_CAP_HI, 8'h01);
    wr(`TMR3_OFF_CNT_LO, 8'h00);
    wr(`TMR3_OFF_CTRL, ctl(4'h3, TMR3_MODE_COMPARE));
    repeat (300) @(posedge clock);
    rdc(`TMR3_OFF_CNT_HI, 8'h00);
    rdc(`TMR3_OFF_CTRL, 8'h40 | ctl(4'h3, TMR3_MODE_COMPARE));
    // reload from 0xFF00 keeps the high byte at the top
    wr(`TMR3_OFF_CTRL, 8'h00);
    wr(`TMR3_OFF_CAP_HI, 8'hFF);
    wr(`TMR3_OFF_CNT_LO, 8'hFF);
    wr(`TMR3_OFF_CNT_HI, 8'hFF);
    wr(`TMR3_OFF_CTRL, ctl(4'h1, TMR3_MODE_RELOAD));
    repeat (50) @(posedge clock);
    rdc(`TMR3_OFF_CNT_HI, 8'hFF);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
